//--- hdl/ssa_slave.sv
`timescale 1ns/1ps
`default_nettype none

module ssa_slave #(
  parameter int TIMEOUT_CYC = ssa_pkg::TIMEOUT_CYC  // shorten in sim
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  output logic                       alert_out,
  output logic                       alert_oe_n,
  input  wire logic                  standby_in_n,
  input  wire logic [1:0]            addr_select_pin_low,
  input  wire logic [1:0]            addr_select_pin_high,
  input  wire ssa_pkg::ssa_meas_t    meas,
  input  wire logic                  remote_open,
  input  wire logic                  status_clear,
  input  wire logic                  alert_mask,
  input  wire logic                  oneshot_req,
  input  wire logic [7:0]            reg_rd_data,
  output ssa_pkg::ssa_reg_req_t      reg_req,
  output logic                       oneshot_go,
  output logic                       hs_mode,
  output logic                       device_enabled,
  output logic                       fault_count_bit2,
  output logic                       fault_count_bit1,
  output logic                       fault_count_bit0
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] link_s;   // {scl, sda} after two flops
  logic [4:0] strap_s;  // {standby, pin high, pin low}
  logic       scl_s;
  logic       sda_s;
  logic       wake_s;

  // bus lines idle high, so reset to high avoids a false start
  ssa_sync #(.W(2), .RST_VAL(2'h3)) u_link_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d_in     ({scl_in, sda_in}),
    .q_out    (link_s)
  );

  ssa_sync #(.W(5), .RST_VAL(5'h00)) u_strap_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d_in     ({standby_in_n, addr_select_pin_high, addr_select_pin_low}),
    .q_out    (strap_s)
  );

  assign scl_s  = link_s[1];
  assign sda_s  = link_s[0];
  assign wake_s = strap_s[4];

  // ----------------------------------------------------------------
  // own address from the three-level pins
  // ----------------------------------------------------------------
  logic [6:0] my_addr;  // seven-bit slave address

  always_comb
  begin
    logic [3:0] hi;
    logic [2:0] lo;
    hi = ssa_pkg::ADR_VCC;
    lo = ssa_pkg::LOW_VCC;
    if (strap_s[1:0] == ssa_pkg::PIN_GND)
    begin
      hi = ssa_pkg::ADR_GND;
      lo = ssa_pkg::LOW_GND;
    end
    else if (strap_s[1:0] == ssa_pkg::PIN_HIZ)
    begin
      hi = ssa_pkg::ADR_HIZ;
      lo = ssa_pkg::LOW_HIZ;
    end
    my_addr = {hi, lo + {1'b0, strap_s[3:2]}};
  end

  // ----------------------------------------------------------------
  // state and bus events
  // ----------------------------------------------------------------
  ssa_pkg::ssa_core_t core_ff;
  ssa_pkg::ssa_core_t nxt_core;

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic to_en;
  logic to_hit;
  logic [2:0] need;     // consecutive results required
  logic pin_act;        // alert pin pulled low by us

  assign scl_rise = scl_s & ~core_ff.scl_q;
  assign scl_fall = ~scl_s & core_ff.scl_q;
  assign start_ev = scl_s & core_ff.scl_q & core_ff.sda_q & ~sda_s;
  assign stop_ev  = scl_s & core_ff.scl_q & ~core_ff.sda_q & sda_s;
  assign to_en    = core_ff.consec[ssa_pkg::TO_EN_BIT];
  assign to_hit   = core_ff.to_cnt ==
                    ssa_pkg::TO_W'(TIMEOUT_CYC - 1);
  // count is one plus set bits
  assign need     = 3'h1 + {2'h0, core_ff.consec[0]}
                  + {2'h0, core_ff.consec[1]}
                  + {2'h0, core_ff.consec[2]};
  assign pin_act  = core_ff.alert & ~alert_mask;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       out_lim;
    logic [2:0] fnext;
    logic       cond;
    out_lim             = 1'b0;
    fnext               = 3'h0;
    // alert cause still present: faults counted or sensor open
    cond                = (core_ff.fcnt != 3'h0) | remote_open;
    nxt_core            = core_ff;
    nxt_core.scl_q      = scl_s;
    nxt_core.sda_q      = sda_s;
    nxt_core.req.wr_stb = 1'b0;
    nxt_core.req.rd_stb = 1'b0;
    nxt_core.os_go      = 1'b0;

    if (core_ff.frame && to_en && (!scl_s || !sda_s))
      nxt_core.to_cnt = core_ff.to_cnt + 1'b1;
    else
      nxt_core.to_cnt = '0;

    case (core_ff.st)
      ssa_pkg::ST_ADDR, ssa_pkg::ST_RX:
      begin
        if (scl_rise)
        begin
          nxt_core.sh  = {core_ff.sh[6:0], sda_s};
          nxt_core.cnt = core_ff.cnt + 1'b1;
        end
        if (scl_fall && core_ff.cnt == 4'h8)
        begin
          nxt_core.cnt = 4'h0;
          nxt_core.st  = ssa_pkg::ST_IGNORE;
          if (core_ff.st == ssa_pkg::ST_RX)
          begin
            nxt_core.drv = 1'b1;
            nxt_core.st  = ssa_pkg::ST_ACK;
            if (core_ff.need_ptr)
            begin
              nxt_core.req.ptr = core_ff.sh;
              nxt_core.need_ptr = 1'b0;
            end
            else
            begin
              nxt_core.req.wr_stb = 1'b1;
              nxt_core.req.wdata  = core_ff.sh;
              if (core_ff.req.ptr == ssa_pkg::PTR_CONSEC)
                nxt_core.consec = core_ff.sh;
            end
          end
          else if (core_ff.sh[7:3] == ssa_pkg::HS_CODE_TOP)
            nxt_core.hs = 1'b1;
          else if (core_ff.sh[7:1] == my_addr)
          begin
            nxt_core.drv      = 1'b1;
            nxt_core.st       = ssa_pkg::ST_ACK;
            nxt_core.rw       = core_ff.sh[0];
            nxt_core.ara      = 1'b0;
            nxt_core.need_ptr = ~core_ff.sh[0];
            if (core_ff.sh[0] && !cond && status_clear)
              nxt_core.alert = 1'b0;
          end
          else if (core_ff.sh == ssa_pkg::ARA_BYTE && pin_act)
          begin
            nxt_core.drv = 1'b1;
            nxt_core.st  = ssa_pkg::ST_ACK;
            nxt_core.rw  = 1'b1;
            nxt_core.ara = 1'b1;
          end
        end
      end

      ssa_pkg::ST_ACK:
      begin
        // ack bit ends on the falling edge
        if (scl_fall)
        begin
          nxt_core.cnt = 4'h0;
          if (core_ff.rw)
          begin
            if (core_ff.ara)
              nxt_core.sh = {my_addr, core_ff.cause_hi};
            else
              nxt_core.sh = reg_rd_data;
            nxt_core.req.rd_stb = ~core_ff.ara;
            nxt_core.drv = ~nxt_core.sh[7];
            nxt_core.st  = ssa_pkg::ST_TX;
          end
          else
          begin
            nxt_core.drv = 1'b0;
            nxt_core.st  = ssa_pkg::ST_RX;
          end
        end
      end

      ssa_pkg::ST_TX:
      begin
        if (scl_rise)
        begin
          nxt_core.cnt = core_ff.cnt + 1'b1;
          // lost when line low, ours high
          if (!core_ff.drv && !sda_s)
            nxt_core.st = ssa_pkg::ST_IGNORE;
        end
        if (scl_fall)
        begin
          if (core_ff.cnt == 4'h8)
          begin
            nxt_core.drv = 1'b0;
            nxt_core.st  = ssa_pkg::ST_RACK;
            if (core_ff.ara)
              nxt_core.alert = 1'b0;
          end
          else
          begin
            nxt_core.sh  = {core_ff.sh[6:0], 1'b0};
            nxt_core.drv = ~core_ff.sh[6];
          end
        end
      end

      ssa_pkg::ST_RACK:
      begin
        if (scl_rise)
        begin
          if (sda_s || core_ff.ara)
            nxt_core.st = ssa_pkg::ST_IGNORE;
          else
            nxt_core.st = ssa_pkg::ST_ACK;
        end
      end

      default:
      begin
        // idle and ignore wait for a start
      end
    endcase

    if (start_ev)
    begin
      nxt_core.st    = ssa_pkg::ST_ADDR;
      nxt_core.cnt   = 4'h0;
      nxt_core.drv   = 1'b0;
      nxt_core.frame = 1'b1;
    end
    if (stop_ev)
    begin
      nxt_core.st    = ssa_pkg::ST_IDLE;
      nxt_core.drv   = 1'b0;
      nxt_core.hs    = 1'b0;
      nxt_core.frame = 1'b0;
    end
    if (to_hit)
    begin
      nxt_core.st    = ssa_pkg::ST_IGNORE;
      nxt_core.drv   = 1'b0;
      nxt_core.frame = 1'b0;
    end

    if (meas.valid && wake_s)
    begin
      out_lim = meas.local_high | meas.local_low
              | meas.remote_high | meas.remote_low;
      fnext = 3'h0;
      if (out_lim)
        fnext = (core_ff.fcnt == ssa_pkg::FCNT_MAX) ?
                core_ff.fcnt : core_ff.fcnt + 1'b1;
      nxt_core.fcnt = fnext;
      if (out_lim && fnext >= need)
      begin
        nxt_core.alert    = 1'b1;
        nxt_core.cause_hi = meas.local_high | meas.remote_high;
      end
    end
    if (remote_open)
      nxt_core.alert = 1'b1;
    nxt_core.os_go = oneshot_req & wake_s;
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      core_ff <= '{st: ssa_pkg::ST_IDLE, scl_q: 1'b1, sda_q: 1'b1,
                  consec: ssa_pkg::CONSEC_RST,
                  req: '{wr_stb: 1'b0, rd_stb: 1'b0,
                         ptr: ssa_pkg::PTR_RST, wdata: 8'h00},
                  default: '0};
    end
    else
    begin
      core_ff <= nxt_core;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain: only a low is driven
  assign sda_out          = 1'b0;
  assign sda_oe_n         = ~core_ff.drv;
  assign alert_out        = 1'b0;
  assign alert_oe_n       = ~pin_act;
  assign reg_req          = core_ff.req;
  assign oneshot_go       = core_ff.os_go;
  assign hs_mode          = core_ff.hs;
  assign device_enabled   = wake_s;
  assign fault_count_bit2 = core_ff.consec[2];
  assign fault_count_bit1 = core_ff.consec[1];
  assign fault_count_bit0 = core_ff.consec[0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_START_ADDR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    start_ev && !to_hit |=> core_ff.st == ssa_pkg::ST_ADDR && !core_ff.drv)
    else $error("start did not open address phase");

  AST_STOP_IDLE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stop_ev && !to_hit |=> core_ff.st == ssa_pkg::ST_IDLE && sda_oe_n)
    else $error("stop did not release and idle");

  AST_HS_EXIT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stop_ev |=> !hs_mode)
    else $error("high speed kept after stop");

  AST_HS_NOACK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(hs_mode) |-> sda_oe_n ##1 sda_oe_n)
    else $error("master code was acknowledged");

  AST_ACK_HELD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    core_ff.st == ssa_pkg::ST_ACK && !core_ff.rw && scl_s |-> !sda_oe_n)
    else $error("ack not held during clock high");

  AST_TIMEOUT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    to_hit |=> sda_oe_n && core_ff.st == ssa_pkg::ST_IGNORE
           ##1 !core_ff.frame)
    else $error("timeout did not release the bus");

  AST_MASK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    alert_mask |-> alert_oe_n)
    else $error("masked alert still driven");

  AST_OPEN: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    remote_open && !alert_mask ##1 !alert_mask |-> !alert_oe_n)
    else $error("open sensor did not assert alert");

  AST_ONESHOT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    oneshot_go |-> $past(wake_s) && $past(oneshot_req))
    else $error("one-shot passed during standby");

  AST_FILTER_ONE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    meas.valid && wake_s && meas.local_high
    && core_ff.fcnt >= need - 3'h1
    |=> core_ff.alert && core_ff.cause_hi)
    else $error("enough faults did not raise alert");

endmodule : ssa_slave

`default_nettype wire

//--- hdl/ssa_pkg.sv
package ssa_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;          // core_clk, 100 MHz
  localparam int TIMEOUT_NS    = 30_000_000;  // bus held low, 30 ms
  // longest time: integer division rounds down
  localparam int TIMEOUT_CYC   = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TO_W          = 22;          // holds 3,000,000

  // ----------------------------------------------------------------
  // bus codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] HS_CODE_TOP = 5'h01;  // 00001xxx master code
  localparam logic [7:0] ARA_BYTE    = 8'h19;  // alert response + read
  localparam logic [7:0] PTR_CONSEC  = 8'h22;  // consecutive-fault reg
  localparam logic [7:0] PTR_RST     = 8'h00;  // pointer after reset
  localparam logic [7:0] CONSEC_RST  = 8'h81;  // timeout on, two faults needed
  localparam int         TO_EN_BIT   = 7;      // timeout enable bit
  localparam logic [2:0] FCNT_MAX    = 3'h4;   // saturate fault count

  // ----------------------------------------------------------------
  // address-select pin levels and address pieces
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_GND  = 2'h0;
  localparam logic [1:0] PIN_HIZ  = 2'h1;
  localparam logic [3:0] ADR_GND  = 4'h3;  // upper nibble, low pin gnd
  localparam logic [3:0] ADR_HIZ  = 4'h5;  // upper nibble, low pin open
  localparam logic [3:0] ADR_VCC  = 4'h9;  // upper nibble, low pin vcc
  localparam logic [2:0] LOW_GND  = 3'h0;  // low bits base per pin
  localparam logic [2:0] LOW_HIZ  = 3'h1;
  localparam logic [2:0] LOW_VCC  = 3'h4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_RACK, ST_IGNORE
  } ssa_state_t;

  // one conversion result, valid for one cycle
  typedef struct packed {
    logic valid;
    logic local_high;
    logic local_low;
    logic remote_high;
    logic remote_low;
  } ssa_meas_t;

  // register access towards the register file
  typedef struct packed {
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } ssa_reg_req_t;

  // whole state of the serial slave
  typedef struct packed {
    ssa_state_t       st;
    logic             scl_q;
    logic             sda_q;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic             rw;
    logic             ara;
    logic             need_ptr;
    logic             drv;
    logic             hs;
    logic             frame;
    logic [TO_W-1:0]  to_cnt;
    logic [7:0]       consec;
    logic             alert;
    logic             cause_hi;
    logic [2:0]       fcnt;
    logic             os_go;
    ssa_reg_req_t     req;
  } ssa_core_t;

endpackage : ssa_pkg

//--- hdl/ssa_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ssa_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // ----------------------------------------------------------------
  // two-stage synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;   // first stage, read only by second
    logic [W-1:0] sync;   // second stage, safe to use
  } ssa_sync_t;

  ssa_sync_t sync_ff;
  ssa_sync_t nxt_sync;

  // next state: plain shift
  always_comb
  begin
    nxt_sync.meta = d_in;
    nxt_sync.sync = sync_ff.meta;
  end

  // register, constant on reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync_ff <= {RST_VAL, RST_VAL};
    end
    else
    begin
      sync_ff <= nxt_sync;
    end
  end

  assign q_out = sync_ff.sync;

endmodule : ssa_sync

`default_nettype wire

//--- tb/ssa_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------
// bus master model, open drain: 1 releases
// ------
module ssa_master_model (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // idle bus: both lines released, clock stands still
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic xfer(input logic o, output logic i);
    #20 sda_m = o;
    #42 scl = 1'b1;
    #31 i = sda;
    #32 scl = 1'b0;
  endtask : xfer

  // start or repeated start
  // long low phase: slave must let go before scl rises
  task automatic start();
    sda_m = 1'b1;
    #62 scl = 1'b1;
    #31 sda_m = 1'b0;
    #31 scl = 1'b0;
  endtask : start

  task automatic stop();
    #20 sda_m = 1'b0;
    #42 scl = 1'b1;
    #31 sda_m = 1'b1;
    #200;
  endtask : stop

  // byte out, ack bit read back
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic d;
    for (int k = 7; k >= 0; k--)
      xfer(b[k], d);
    xfer(1'b1, ack);
  endtask : wbyte

  // byte in, master acks or ends with nack
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic d;
    for (int k = 7; k >= 0; k--)
      xfer(1'b1, b[k]);
    xfer(nack, d);
  endtask : rbyte
endmodule : ssa_master_model

`default_nettype wire

//--- tb/test_sensor_serial_slave_alert.sv
`timescale 1ns/1ps
`default_nettype none

module test_sensor_serial_slave_alert;
  // ------
  // wiring
  // ------
  localparam logic [7:0] OWN_W = 8'h30;  // both pins gnd, write
  localparam logic [7:0] OWN_R = 8'h31;  // same address, read
  logic                  core_clk     = 1'b0;
  logic                  rst_n        = 1'b0;
  logic                  standby_in_n = 1'b1;
  logic                  remote_open  = 1'b0;
  logic                  status_clear = 1'b0;
  logic                  alert_mask   = 1'b0;
  logic                  oneshot_req  = 1'b0;
  logic [1:0]            pin_lo       = 2'h0;
  logic [1:0]            pin_hi       = 2'h0;
  logic [7:0]            reg_rd_data  = 8'ha5;
  ssa_pkg::ssa_meas_t    meas         = '0;
  ssa_pkg::ssa_reg_req_t reg_req;
  logic                  scl, sda_m, sda_out, sda_oe_n;
  logic                  alert_out, alert_oe_n, oneshot_go;
  logic                  hs_mode, device_enabled, fc2, fc1, fc0;
  logic                  a;
  logic [7:0]            b;
  int                    bad_count    = 0;
  int                    tests_run    = 0;
  int                    wr_seen      = 0;  // write strobes counted
  int                    rd_seen      = 0;  // read strobes counted
  wire logic             sda;

  // pull-up: line low only while someone pulls it
  assign sda = sda_m & (sda_oe_n | sda_out);

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  ssa_master_model mst (.scl(scl), .sda_m(sda_m), .sda(sda));

  ssa_slave #(.TIMEOUT_CYC(200)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .standby_in_n(standby_in_n),
    .addr_select_pin_low(pin_lo), .addr_select_pin_high(pin_hi),
    .meas(meas), .remote_open(remote_open),
    .status_clear(status_clear), .alert_mask(alert_mask),
    .oneshot_req(oneshot_req), .reg_rd_data(reg_rd_data),
    .reg_req(reg_req), .oneshot_go(oneshot_go), .hs_mode(hs_mode),
    .device_enabled(device_enabled), .fault_count_bit2(fc2),
    .fault_count_bit1(fc1), .fault_count_bit0(fc0));

  // strobes last one cycle: count them so none goes unseen
  always @(posedge core_clk)
  begin
    if (reg_req.wr_stb === 1'b1)
      wr_seen++;
    if (reg_req.rd_stb === 1'b1)
      rd_seen++;
  end

  // ------
  // helpers
  // ------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one conversion result, valid for a single cycle
  task automatic mpulse(input logic [3:0] f);
    cyc(1);
    meas <= {1'b1, f};
    cyc(1);
    meas <= '0;
    cyc(3);
  endtask : mpulse

  // pulse the one-shot command, note any go pulse after it
  task automatic os_try(output logic [7:0] s);
    s = 8'h00;
    oneshot_req <= 1'b1;
    cyc(1);
    oneshot_req <= 1'b0;
    repeat (4)
    begin
      cyc(1);
      s = s | {7'h00, oneshot_go};
    end
  endtask : os_try

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    chk("sda_oe_n", 8'h01, sda_oe_n);
    chk("alert_oe_n", 8'h01, alert_oe_n);
    chk("hs_mode", 8'h00, hs_mode);
    chk("fault_bits", 8'h01, {fc2, fc1, fc0});
    chk("sda_out", 8'h00, sda_out);
    chk("alert_out", 8'h00, alert_out);
  endtask : t_reset

  // hang the bus during our own ack; slave must let go
  task automatic t_timeout();
    mst.start();
    for (int k = 7; k >= 0; k--)
      mst.xfer(OWN_W[k], a);
    cyc(100);
    chk("ack_held", 8'h00, sda_oe_n);
    cyc(150);
    chk("to_release", 8'h01, sda_oe_n);
    mst.stop();
  endtask : t_timeout

  task automatic t_write();
    // low pin vcc, high pin open: address 1001 101
    pin_lo <= 2'h2;
    pin_hi <= 2'h1;
    cyc(4);
    mst.start();
    mst.wbyte(8'h9a, a);
    chk("ack_pins", 8'h00, a);
    mst.stop();
    pin_lo <= 2'h0;
    pin_hi <= 2'h0;
    cyc(4);
    mst.start();
    mst.wbyte(8'h32, a);
    chk("ack_other", 8'h01, a);
    mst.stop();
    mst.start();
    mst.wbyte(OWN_W, a);
    chk("ack_addr", 8'h00, a);
    mst.wbyte(ssa_pkg::PTR_CONSEC, a);
    chk("ack_ptr", 8'h00, a);
    mst.wbyte(8'h83, a);
    chk("ack_data", 8'h00, a);
    mst.stop();
    cyc(2);
    chk("ptr", ssa_pkg::PTR_CONSEC, reg_req.ptr);
    chk("wdata", 8'h83, reg_req.wdata);
    chk("fault_bits", 8'h03, {fc2, fc1, fc0});
    chk("wr_stb", 8'h01, 8'(wr_seen));
  endtask : t_write

  task automatic t_hs();
    mst.start();
    mst.wbyte(8'h0d, a);
    chk("ack_hs_code", 8'h01, a);
    cyc(2);
    chk("hs_mode", 8'h01, hs_mode);
    mst.start();
    mst.wbyte(OWN_W, a);
    chk("ack_hs_addr", 8'h00, a);
    mst.stop();
    cyc(2);
    chk("hs_mode", 8'h00, hs_mode);
  endtask : t_hs

  // three faults needed; high then low crossing
  task automatic t_alert();
    for (int i = 1; i >= 0; i--)
    begin
      mpulse(4'h0);
      mpulse(i[0] ? 4'h8 : 4'h4);
      mpulse(i[0] ? 4'h8 : 4'h4);
      chk("alert_early", 8'h01, alert_oe_n);
      mpulse(i[0] ? 4'h8 : 4'h4);
      chk("alert_set", 8'h00, alert_oe_n);
      alert_mask <= 1'b1;
      cyc(2);
      chk("alert_masked", 8'h01, alert_oe_n);
      alert_mask <= 1'b0;
      mst.start();
      mst.wbyte(ssa_pkg::ARA_BYTE, a);
      chk("ack_ara", 8'h00, a);
      mst.rbyte(1'b1, b);
      chk("ara_byte", {OWN_W[7:1], i[0]}, b);
      mst.stop();
      cyc(2);
      chk("alert_released", 8'h01, alert_oe_n);
    end
  endtask : t_alert

  task automatic t_read();
    cyc(1);
    remote_open <= 1'b1;
    cyc(1);
    remote_open <= 1'b0;
    cyc(2);
    chk("alert_open", 8'h00, alert_oe_n);
    status_clear <= 1'b1;
    mpulse(4'h0);
    mst.start();
    mst.wbyte(OWN_R, a);
    chk("ack_read", 8'h00, a);
    mst.rbyte(1'b0, b);
    chk("read_data", reg_rd_data, b);
    mst.rbyte(1'b1, b);
    chk("read_last", reg_rd_data, b);
    mst.stop();
    cyc(2);
    chk("alert_cleared", 8'h01, alert_oe_n);
    chk("ptr_kept", ssa_pkg::PTR_CONSEC, reg_req.ptr);
    chk("rd_stb", 8'h02, 8'(rd_seen));
  endtask : t_read

  task automatic t_standby();
    cyc(1);
    standby_in_n <= 1'b0;
    cyc(4);
    chk("enabled", 8'h00, device_enabled);
    os_try(b);
    chk("oneshot_off", 8'h00, b);
    standby_in_n <= 1'b1;
    cyc(4);
    chk("enabled", 8'h01, device_enabled);
    os_try(b);
    chk("oneshot_on", 8'h01, b);
  endtask : t_standby

  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ------
  // main sequence
  // ------
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_timeout();
    t_write();
    t_hs();
    t_alert();
    t_read();
    t_standby();
    summarize();
  end
endmodule : test_sensor_serial_slave_alert

`default_nettype wire
